// ### qu_char_frame.sv
// received character alignment and error checks
module qu_char_frame
  import qu_pkg::*;
(
  input wire logic [QU_RAW_W-1:0] rawBits,
  input wire logic [1:0] charLen,
  input wire logic parityOn,
  input wire logic parityEven,
  input wire logic stopOk,
  output logic [7:0] charData,
  output logic frameErr,
  output logic parityErr,
  output logic breakSeen
);
  logic [3:0] nBits;
  logic parBit;

  always_comb
  begin
    nBits = QU_MIN_CHAR_BITS + {2'b00, charLen};
    charData = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      if (4'(i) < nBits)
      begin
        charData[i] = rawBits[i];
      end
    end
    parBit = rawBits[nBits];
    frameErr = ~stopOk;
    parityErr = parityOn & ((^charData ^ parBit) == parityEven);
    breakSeen = frameErr & (charData == 8'h00) & (~parityOn | ~parBit);
  end

endmodule : qu_char_frame

// ### qu_host_model.sv
// host processor model on the register bus
module qu_host_model
(
  input wire logic mclk,
  output logic [4:0] addr,
  output logic rdStrobe,
  output logic wrStrobe,
  output logic [7:0] wrData,
  input wire logic [7:0] rdData
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    addr = 5'h00;
    rdStrobe = 1'b0;
    wrStrobe = 1'b0;
    wrData = 8'h00;
  end
  // plain write, never read-modify-write
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge mclk);
    addr = a;
    wrData = d;
    wrStrobe = 1'b1;
    @(negedge mclk);
    wrStrobe = 1'b0;
    wrData = ~d;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(negedge mclk);
    addr = a;
    rdStrobe = 1'b1;
    @(negedge mclk);
    rdStrobe = 1'b0;
    d = rdData;
  endtask : rd
endmodule : qu_host_model

// ### qu_line_status_format.sv
// four-line status flags, format and command registers
module qu_line_status_format
  import qu_pkg::*;
#(
  parameter int LINES = QU_LINES
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [4:0] addr,
  input wire logic rdStrobe,
  input wire logic wrStrobe,
  input wire logic [7:0] wrData,
  output logic [7:0] rdData,
  input wire logic [LINES-1:0] dsrN,
  input wire logic [LINES-1:0] dcdN,
  input wire logic [LINES-1:0] rxCharValid,
  input wire logic [LINES*QU_RAW_W-1:0] rxRawBits,
  input wire logic [LINES-1:0] rxStopOk,
  input wire logic [LINES-1:0] txTake,
  input wire logic [LINES-1:0] txCharDone,
  output logic [LINES*8-1:0] txHoldData,
  output logic [LINES-1:0] txHoldValid,
  output logic [LINES*2-1:0] stopSel,
  output logic [LINES-1:0] parityOn,
  output logic [LINES-1:0] parityEven,
  output logic [LINES*2-1:0] charLenSel,
  output logic [LINES*8-1:0] baudSel,
  output logic [LINES*2-1:0] opMode,
  output logic [LINES-1:0] txBreak,
  output logic [LINES-1:0] rxIntEnable,
  output logic [LINES-1:0] txIntEnable,
  output logic [LINES-1:0] rxEnable,
  output logic [LINES-1:0] txEnable,
  output logic [LINES-1:0] rxBreakSeen
);
  logic [QU_LINE_W-1:0] lineAddr;
  logic [2:0] regAddr;
  logic [7:0] lineStatus [LINES];
  logic [7:0] lineFormat [LINES];
  logic [7:0] lineCommand [LINES];
  logic [7:0] lineRxData [LINES];
  logic [7:0] next_rdData;

  // line select high, register select low
  assign lineAddr = addr[4:3];
  assign regAddr = addr[2:0];

  genvar g;
  generate
    for (g = 0; g < LINES; g++)
    begin : gLine
      logic lineSel;
      logic accRd;
      logic accWr;
      logic [7:0] command;
      logic [7:0] format1;
      logic [7:0] format2;
      qu_fmt_sel_t fmtPtr;
      qu_mode_t mode;
      logic rxEnEff;
      logic txEnEff;
      logic [7:0] txHold;
      logic holdFull;
      logic hostLoad;
      logic txIdle;
      logic txReady;
      logic [7:0] rxChar;
      logic rxFer;
      logic rxPer;
      logic rxBrk;
      logic [QU_ENTRY_W-1:0] head;
      logic headLoad;
      logic rxEmpty;
      logic rxFull;
      logic rxPush;
      logic rxPop;
      logic errShow;
      logic overrun;
      logic frameFlag;
      logic parityFlag;

      assign lineSel = (lineAddr == QU_LINE_W'(g));
      assign accRd = rdStrobe & lineSel;
      assign accWr = wrStrobe & lineSel;
      assign mode = qu_mode_t'(command[QU_CMD_MODE_LSB +: 2]);

      // remote loopback holds both enables off; echo disables transmitter
      assign rxEnEff = command[QU_CMD_RX_ENABLE_BIT] & (mode != QU_MODE_REMOTE);
      assign txEnEff = command[QU_CMD_TX_ENABLE_BIT]
        & ((mode == QU_MODE_NORMAL) | (mode == QU_MODE_LOCAL));

      // command register
      always_ff @(posedge mclk)
      begin
        if (rst)
        begin
          command <= QU_CMD_RESET;
        end
        else if (ce && accWr && regAddr == QU_REG_COMMAND)
        begin
          command <= wrData;
        end
      end

      // alternating pointer over the shared format address
      always_ff @(posedge mclk)
      begin
        if (rst)
        begin
          fmtPtr <= QU_FMT_FIRST;
        end
        else if (ce)
        begin
          if (accRd && regAddr == QU_REG_COMMAND)
          begin
            fmtPtr <= QU_FMT_FIRST;
          end
          else if ((accRd || accWr) && regAddr == QU_REG_FORMAT)
          begin
            case (fmtPtr)
              QU_FMT_FIRST: fmtPtr <= QU_FMT_SECOND;
              QU_FMT_SECOND: fmtPtr <= QU_FMT_FIRST;
              default: fmtPtr <= QU_FMT_FIRST;
            endcase
          end
        end
      end

      // format registers
      always_ff @(posedge mclk)
      begin
        if (rst)
        begin
          format1 <= QU_FMT1_RESET;
          format2 <= QU_FMT2_RESET;
        end
        else if (ce && accWr && regAddr == QU_REG_FORMAT)
        begin
          if (fmtPtr == QU_FMT_FIRST)
          begin
            format1 <= wrData;
          end
          else
          begin
            format2 <= wrData;
          end
        end
      end

      // transmit holding register, overwritten by any later load
      assign hostLoad = ce & accWr & (regAddr == QU_REG_DATA);

      always_ff @(posedge mclk)
      begin
        if (rst)
        begin
          txHold <= 8'h00;
          holdFull <= 1'b0;
        end
        else if (ce)
        begin
          if (accWr && regAddr == QU_REG_DATA)
          begin
            txHold <= wrData;
            holdFull <= 1'b1;
          end
          else if (txTake[g] && txEnEff && holdFull)
          begin
            holdFull <= 1'b0;
          end
        end
      end

      // empty holding register seen only while transmitter runs
      assign txReady = txEnEff & ~holdFull;

      // serializer idle flag
      always_ff @(posedge mclk)
      begin
        if (rst)
        begin
          txIdle <= 1'b0;
        end
        else if (ce)
        begin
          if (hostLoad || !txEnEff)
          begin
            txIdle <= 1'b0;
          end
          else if (txCharDone[g] && !holdFull)
          begin
            txIdle <= 1'b1;
          end
        end
      end

      qu_char_frame uFrame (
        .rawBits(rxRawBits[g*QU_RAW_W +: QU_RAW_W]),
        .charLen(format1[QU_FMT_LEN_LSB +: 2]),
        .parityOn(format1[QU_FMT_PAR_ON]),
        .parityEven(format1[QU_FMT_PAR_EVEN]),
        .stopOk(rxStopOk[g]),
        .charData(rxChar),
        .frameErr(rxFer),
        .parityErr(rxPer),
        .breakSeen(rxBrk)
      );

      assign rxPush = rxCharValid[g] & rxEnEff;
      assign rxPop = accRd & (regAddr == QU_REG_DATA) & ~rxEmpty;

      // receiver flushed while disabled
      qu_rx_fifo #(
        .WIDTH(QU_ENTRY_W),
        .DEPTH(QU_RX_DEPTH)
      ) uFifo (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .flush(~rxEnEff),
        .push(rxPush),
        .wrData({rxBrk, rxPer, rxFer, rxChar}),
        .pop(rxPop),
        .head(head),
        .headLoad(headLoad),
        .empty(rxEmpty),
        .full(rxFull)
      );

      // per-character errors shown until cleared or character replaced
      always_ff @(posedge mclk)
      begin
        if (rst)
        begin
          errShow <= 1'b0;
        end
        else if (ce)
        begin
          if (headLoad)
          begin
            errShow <= 1'b1;
          end
          else if (command[QU_CMD_ERRCLR] || !rxEnEff)
          begin
            errShow <= 1'b0;
          end
        end
      end

      // overrun when a character arrives with the buffer full
      always_ff @(posedge mclk)
      begin
        if (rst)
        begin
          overrun <= 1'b0;
        end
        else if (ce)
        begin
          if (rxPush && rxFull)
          begin
            overrun <= 1'b1;
          end
          else if (command[QU_CMD_ERRCLR] || !rxEnEff)
          begin
            overrun <= 1'b0;
          end
        end
      end

      assign frameFlag = errShow & ~rxEmpty & head[QU_ENT_FER];
      assign parityFlag = errShow & ~rxEmpty & head[QU_ENT_PER]
        & format1[QU_FMT_PAR_ON];

      // status is assembled live; bus writes never reach it
      always_comb
      begin
        lineStatus[g] = 8'h00;
        lineStatus[g][QU_ST_DSR] = ~dsrN[g];
        lineStatus[g][QU_ST_DCD] = ~dcdN[g];
        lineStatus[g][QU_ST_FRAME] = frameFlag;
        lineStatus[g][QU_ST_OVERRUN] = overrun;
        lineStatus[g][QU_ST_PARITY] = parityFlag;
        lineStatus[g][QU_ST_TXIDLE] = txIdle;
        lineStatus[g][QU_ST_RXAVAIL] = ~rxEmpty;
        lineStatus[g][QU_ST_TXHOLD] = txReady;
      end

      assign lineFormat[g] = (fmtPtr == QU_FMT_FIRST) ? format1 : format2;
      assign lineCommand[g] = command;
      assign lineRxData[g] = rxEmpty ? 8'h00 : head[7:0];

      assign txHoldData[g*8 +: 8] = txHold;
      assign txHoldValid[g] = holdFull & txEnEff;
      assign stopSel[g*2 +: 2] = format1[QU_FMT_STOP_LSB +: 2];
      assign parityOn[g] = format1[QU_FMT_PAR_ON];
      assign parityEven[g] = format1[QU_FMT_PAR_EVEN];
      assign charLenSel[g*2 +: 2] = format1[QU_FMT_LEN_LSB +: 2];
      assign baudSel[g*8 +: 8] = format2;
      assign opMode[g*2 +: 2] = command[QU_CMD_MODE_LSB +: 2];
      assign txBreak[g] = command[QU_CMD_TXBRK];
      assign rxIntEnable[g] = command[QU_CMD_RXIE];
      assign txIntEnable[g] = command[QU_CMD_TXIE];
      assign rxEnable[g] = rxEnEff;
      assign txEnable[g] = txEnEff;
      assign rxBreakSeen[g] = frameFlag & head[QU_ENT_BRK];
    end
  endgenerate

  // read data mux
  always_comb
  begin
    next_rdData = 8'h00;
    if (regAddr == QU_REG_DATA)
    begin
      next_rdData = lineRxData[lineAddr];
    end
    else if (regAddr == QU_REG_STATUS)
    begin
      next_rdData = lineStatus[lineAddr];
    end
    else if (regAddr == QU_REG_FORMAT)
    begin
      next_rdData = lineFormat[lineAddr];
    end
    else if (regAddr == QU_REG_COMMAND)
    begin
      next_rdData = lineCommand[lineAddr];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rdData <= 8'h00;
    end
    else if (ce && rdStrobe)
    begin
      rdData <= next_rdData;
    end
  end

endmodule : qu_line_status_format

// ### qu_line_status_format_chk.sv
// port assertions for the line status and format block
module qu_line_status_format_chk
  import qu_pkg::*;
#(
  parameter int LINES = QU_LINES
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [4:0] addr,
  input wire logic rdStrobe,
  input wire logic wrStrobe,
  input wire logic [7:0] wrData,
  input wire logic [7:0] rdData,
  input wire logic [LINES-1:0] dsrN,
  input wire logic [LINES-1:0] dcdN,
  input wire logic [LINES-1:0] txTake,
  input wire logic [LINES-1:0] txHoldValid,
  input wire logic [LINES*2-1:0] stopSel,
  input wire logic [LINES-1:0] parityOn,
  input wire logic [LINES*2-1:0] charLenSel,
  input wire logic [LINES*2-1:0] opMode,
  input wire logic [LINES-1:0] rxEnable,
  input wire logic [LINES-1:0] txEnable
);
  timeunit 1ns;
  timeprecision 1ps;
  logic fmtSecond;
  logic [4:0] fmt0;
  assign fmt0 = {stopSel[1:0], parityOn[0], charLenSel[1:0]};
  // line 0 format pointer shadow
  always_ff @(posedge mclk)
  begin
    if (rst && ce)
      fmtSecond <= 1'b0;
    else if (ce && rdStrobe && addr == 5'h03)
      fmtSecond <= 1'b0;
    else if (ce && (rdStrobe || wrStrobe) && addr == 5'h02)
      fmtSecond <= !fmtSecond;
  end
  modem_bits_a: assert property (@(posedge mclk) disable iff (rst)
    ce && rdStrobe && addr == 5'h01 |=> rdData[7:6] == ~$past({dsrN[0], dcdN[0]}))
    else $error("modem status bits wrong");
  fmt_first_write_a: assert property (@(posedge mclk) disable iff (rst)
    ce && wrStrobe && addr == 5'h02 && !fmtSecond |=> fmt0 == $past({wrData[7:6], wrData[4:2]}))
    else $error("first format register not loaded");
  fmt_second_keep_a: assert property (@(posedge mclk) disable iff (rst)
    ce && wrStrobe && addr == 5'h02 && fmtSecond |=> $stable(fmt0))
    else $error("second format write changed first");
  fmt_reset_a: assert property (@(posedge mclk) disable iff (rst)
    $past(rst) && $past(ce) |-> fmt0 == 5'h00)
    else $error("format fields not cleared by reset");
  echo_tx_off_a: assert property (@(posedge mclk) disable iff (rst)
    opMode[1:0] == QU_MODE_ECHO || opMode[1:0] == QU_MODE_REMOTE |-> !txEnable[0] && !txHoldValid[0])
    else $error("transmitter active in echo or remote");
  remote_rx_off_a: assert property (@(posedge mclk) disable iff (rst)
    opMode[1:0] == QU_MODE_REMOTE |-> !rxEnable[0])
    else $error("receiver active in remote loopback");
  hold_load_a: assert property (@(posedge mclk) disable iff (rst)
    ce && wrStrobe && addr == 5'h00 && txEnable[0] && !txTake[0] |=> txHoldValid[0])
    else $error("holding register not loaded");
  hold_take_a: assert property (@(posedge mclk) disable iff (rst)
    ce && txTake[0] && txHoldValid[0] && !(wrStrobe && addr == 5'h00) |=> !txHoldValid[0])
    else $error("holding register not emptied");
  unmapped_zero_a: assert property (@(posedge mclk) disable iff (rst)
    ce && rdStrobe && addr[2] |=> rdData == 8'h00)
    else $error("unmapped read not zero");
endmodule : qu_line_status_format_chk

bind qu_line_status_format qu_line_status_format_chk #(.LINES(LINES)) u_chk (
  .mclk, .rst, .ce, .addr, .rdStrobe, .wrStrobe, .wrData, .rdData, .dsrN, .dcdN,
  .txTake, .txHoldValid, .stopSel, .parityOn, .charLenSel, .opMode, .rxEnable,
  .txEnable);

// ### qu_pkg.sv
// constants and types for the serial line status and format block
// Contract
// - status bits 7,6 show inverted modem inputs
// - bit 5 flags missing first stop bit
// - framing error with all-zero character means break
// - error flags clear by rx disable, reset, clear bit
// - bit 4 flags character lost to full buffer
// - bit 3 flags bad parity, clears on read; code shows the head character's parity error, status reads leave it
// - bit 2 flags serializer idle, nothing pending
// - bit 1 flags received character waiting
// - bit 0 flags empty transmit holding register
// - transmit-ready sets once enabled with empty holding
// - transmit-ready stays clear in echo, remote loopback
// - write while not ready replaces pending character
// - status register is read only
// - two format registers share one alternating address
// - pointer returns first on reset, command read
// - format bits 7:6 select stop bits
// - format bits 5:4 select parity mode
// - format bits 3:2 select five to eight bits
// - short characters right aligned, parity bit hidden
// - first format register clears on reset
// - command bit 4 clears the three error flags
// - rx disable aborts, clears flags, initialises receiver
// - address top bits pick line, low bits register
package qu_pkg;

  localparam int QU_LINES = 4;
  localparam int QU_LINE_W = 2;
  localparam int QU_RAW_W = 9;
  localparam int QU_RX_DEPTH = 2;
  localparam int QU_ENTRY_W = 11;

  // register select within a line
  localparam logic [2:0] QU_REG_DATA = 3'h0;
  localparam logic [2:0] QU_REG_STATUS = 3'h1;
  localparam logic [2:0] QU_REG_FORMAT = 3'h2;
  localparam logic [2:0] QU_REG_COMMAND = 3'h3;

  // status bit positions
  localparam int QU_ST_DSR = 7;
  localparam int QU_ST_DCD = 6;
  localparam int QU_ST_FRAME = 5;
  localparam int QU_ST_OVERRUN = 4;
  localparam int QU_ST_PARITY = 3;
  localparam int QU_ST_TXIDLE = 2;
  localparam int QU_ST_RXAVAIL = 1;
  localparam int QU_ST_TXHOLD = 0;

  // first format register fields
  localparam int QU_FMT_STOP_LSB = 6;
  localparam int QU_FMT_PAR_EVEN = 5;
  localparam int QU_FMT_PAR_ON = 4;
  localparam int QU_FMT_LEN_LSB = 2;
  localparam logic [3:0] QU_MIN_CHAR_BITS = 4'h5;

  // command register bits
  localparam int QU_CMD_MODE_LSB = 6;
  localparam int QU_CMD_RXIE = 5;
  localparam int QU_CMD_ERRCLR = 4;
  localparam int QU_CMD_TXBRK = 3;
  localparam int QU_CMD_RX_ENABLE_BIT = 2;
  localparam int QU_CMD_TXIE = 1;
  localparam int QU_CMD_TX_ENABLE_BIT = 0;

  localparam logic [7:0] QU_FMT1_RESET = 8'h00;
  localparam logic [7:0] QU_FMT2_RESET = 8'h00;
  localparam logic [7:0] QU_CMD_RESET = 8'h00;

  // fifo entry layout
  localparam int QU_ENT_FER = 8;
  localparam int QU_ENT_PER = 9;
  localparam int QU_ENT_BRK = 10;

  typedef enum logic [1:0] {
    QU_MODE_NORMAL = 2'b00,
    QU_MODE_ECHO = 2'b01,
    QU_MODE_LOCAL = 2'b10,
    QU_MODE_REMOTE = 2'b11
  } qu_mode_t;

  typedef enum logic {
    QU_FMT_FIRST = 1'b0,
    QU_FMT_SECOND = 1'b1
  } qu_fmt_sel_t;

endpackage : qu_pkg

// ### qu_rx_fifo.sv
// receive buffer with registered head entry
module qu_rx_fifo
  import qu_pkg::*;
#(
  parameter int WIDTH = QU_ENTRY_W,
  parameter int DEPTH = QU_RX_DEPTH
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic flush,
  input wire logic push,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic pop,
  output logic [WIDTH-1:0] head,
  output logic headLoad,
  output logic empty,
  output logic full
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [CW-1:0] count;
  logic doPush;
  logic doPop;
  logic [AW-1:0] next_rdPtr;
  logic [AW-1:0] next_wrPtr;

  assign empty = (count == '0);
  assign full = (count == FULL_COUNT);
  assign doPush = push & ~full;
  assign doPop = pop & ~empty;
  assign next_rdPtr = (rdPtr == LAST_PTR) ? '0 : AW'(rdPtr + 1'b1);
  assign next_wrPtr = (wrPtr == LAST_PTR) ? '0 : AW'(wrPtr + 1'b1);

  always_ff @(posedge mclk)
  begin
    if (ce && doPush)
    begin
      mem[wrPtr] <= wrData;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      headLoad <= 1'b0;
      head <= '0;
    end
    else if (ce)
    begin
      if (flush)
      begin
        wrPtr <= '0;
        rdPtr <= '0;
        count <= '0;
        headLoad <= 1'b0;
      end
      else
      begin
        if (doPush)
        begin
          wrPtr <= next_wrPtr;
        end
        if (doPop)
        begin
          rdPtr <= next_rdPtr;
        end
        if (doPush && !doPop)
        begin
          count <= CW'(count + 1'b1);
        end
        else if (doPop && !doPush)
        begin
          count <= CW'(count - 1'b1);
        end
        headLoad <= 1'b0;
        if (doPop && count > CW'(1))
        begin
          head <= mem[next_rdPtr];
          headLoad <= 1'b1;
        end
        else if (doPush && (empty || (doPop && count == CW'(1))))
        begin
          head <= wrData;
          headLoad <= 1'b1;
        end
      end
    end
  end

endmodule : qu_rx_fifo

// ### test_quad_uart_line_status_and_format.sv
// testbench for the line status and format block
module test_quad_uart_line_status_and_format
  import qu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst, ce, rdStrobe, wrStrobe;
  logic [4:0] addr;
  logic [7:0] wrData, rdData;
  logic [3:0] dsrN, dcdN, rxCharValid, rxStopOk, txTake, txCharDone;
  logic [3:0] txHoldValid, parityOn, parityEven, rxBreakSeen;
  logic [4*QU_RAW_W-1:0] rxRawBits;
  logic [31:0] txHoldData, baudSel;
  logic [7:0] stopSel, charLenSel, opMode;
  logic [3:0] txBreak, rxIntEnable, txIntEnable, rxEnable, txEnable;
  int n_fail = 0;
  int cmp_count = 0;
  qu_line_status_format u_dut (.mclk, .rst, .ce, .addr, .rdStrobe, .wrStrobe, .wrData,
    .rdData, .dsrN, .dcdN, .rxCharValid, .rxRawBits, .rxStopOk, .txTake, .txCharDone,
    .txHoldData, .txHoldValid, .stopSel, .parityOn, .parityEven, .charLenSel, .baudSel,
    .opMode, .txBreak, .rxIntEnable, .txIntEnable, .rxEnable, .txEnable,
    .rxBreakSeen);
  qu_host_model u_host (.mclk, .addr, .rdStrobe, .wrStrobe, .wrData, .rdData);
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdchk(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_host.rd(a, d);
    chk(d, exp);
  endtask : rdchk
  // one deserialized character on line 0
  task automatic push(input logic [8:0] raw, input logic ok);
    @(negedge mclk);
    rxRawBits[8:0] = raw;
    rxStopOk[0] = ok;
    rxCharValid[0] = 1'b1;
    @(negedge mclk);
    rxCharValid[0] = 1'b0;
    rxRawBits[8:0] = ~raw;
    rxStopOk[0] = ~ok;
  endtask : push
  task automatic t_modem;
    dsrN = 4'hE;
    rdchk(5'h01, 8'h80);
    dcdN = 4'hE;
    u_host.wr(5'h01, 8'hFF);
    rdchk(5'h01, 8'hC0);
    rdchk(5'h09, 8'h00);
    dsrN = 4'hF;
    dcdN = 4'hF;
  endtask : t_modem
  task automatic t_format;
    for (int i = 0; i < 4; i++)
    begin
      u_host.wr(5'h02, {i[1:0], i[1:0], i[1:0], 2'h0});
      rdchk(5'h03, 8'h00);
      chk({6'h0, stopSel[1:0]}, i[7:0]);
      chk({7'h0, parityOn[0]}, {7'h0, i[0]});
      if (i[0])
        chk({7'h0, parityEven[0]}, {7'h0, i[1]});
      chk({6'h0, charLenSel[1:0]}, i[7:0]);
    end
    u_host.wr(5'h02, 8'hDD);
    u_host.wr(5'h02, 8'h5A);
    chk(baudSel[7:0], 8'h5A);
    rdchk(5'h02, 8'hDD);
    rdchk(5'h02, 8'h5A);
    rdchk(5'h02, 8'hDD);
    rdchk(5'h03, 8'h00);
    rdchk(5'h02, 8'hDD);
    u_host.wr(5'h12, 8'h40);
    chk({6'h0, stopSel[5:4]}, 8'h01);
    rdchk(5'h07, 8'h00);
  endtask : t_format
  task automatic t_rx;
    rdchk(5'h03, 8'h00);
    u_host.wr(5'h02, 8'h70);
    u_host.wr(5'h03, 8'h04);
    push(9'h1D5, 1'b0);
    push(9'h00A, 1'b1);
    push(9'h003, 1'b1);
    rdchk(5'h01, 8'h3A);
    chk({7'h0, rxBreakSeen[0]}, 8'h00);
    rdchk(5'h00, 8'h15);
    rdchk(5'h01, 8'h12);
    u_host.wr(5'h03, 8'h14);
    rdchk(5'h01, 8'h02);
    rdchk(5'h00, 8'h0A);
    rdchk(5'h01, 8'h00);
    u_host.wr(5'h03, 8'h04);
    push(9'h000, 1'b0);
    @(negedge mclk);
    chk({7'h0, rxBreakSeen[0]}, 8'h01);
    u_host.wr(5'h03, 8'h00);
    rdchk(5'h01, 8'h00);
    rdchk(5'h00, 8'h00);
  endtask : t_rx
  task automatic t_tx;
    u_host.wr(5'h03, 8'h01);
    rdchk(5'h01, 8'h01);
    u_host.wr(5'h00, 8'h41);
    u_host.wr(5'h00, 8'h42);
    chk(txHoldData[7:0], 8'h42);
    rdchk(5'h01, 8'h00);
    @(negedge mclk);
    txTake[0] = 1'b1;
    @(negedge mclk);
    txTake[0] = 1'b0;
    txCharDone[0] = 1'b1;
    @(negedge mclk);
    txCharDone[0] = 1'b0;
    rdchk(5'h01, 8'h05);
    u_host.wr(5'h00, 8'h43);
    rdchk(5'h01, 8'h00);
    @(negedge mclk);
    txTake[0] = 1'b1;
    @(negedge mclk);
    txTake[0] = 1'b0;
    rdchk(5'h01, 8'h01);
    u_host.wr(5'h03, 8'h41);
    rdchk(5'h01, 8'h00);
    u_host.wr(5'h03, 8'hC5);
    rdchk(5'h01, 8'h00);
    chk({6'h0, opMode[1:0]}, 8'h03);
    u_host.wr(5'h03, 8'h81);
    rdchk(5'h01, 8'h01);
    u_host.wr(5'h03, 8'h01);
    rdchk(5'h01, 8'h01);
    u_host.wr(5'h03, 8'h2E);
    chk({4'h0, txBreak[0], rxIntEnable[0], txIntEnable[0], rxEnable[0]}, 8'h0F);
    u_host.wr(5'h03, 8'h00);
    rdchk(5'h01, 8'h00);
    ce = 1'b0;
    u_host.wr(5'h03, 8'h01);
    ce = 1'b1;
    rdchk(5'h03, 8'h00);
  endtask : t_tx
  task automatic t_reset;
    u_host.wr(5'h03, 8'h05);
    @(negedge mclk);
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    chk({3'h0, stopSel[1:0], parityOn[0], charLenSel[1:0]}, 8'h00);
    rdchk(5'h02, 8'h00);
    rdchk(5'h01, 8'h00);
    rdchk(5'h03, 8'h00);
  endtask : t_reset
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    dsrN = 4'hF;
    dcdN = 4'hF;
    rxCharValid = 4'h0;
    rxRawBits = 36'h0;
    rxStopOk = 4'h0;
    txTake = 4'h0;
    txCharDone = 4'h0;
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    t_modem();
    t_format();
    t_rx();
    t_tx();
    t_reset();
    complete_run();
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    complete_run();
  end
endmodule : test_quad_uart_line_status_and_format
